// file: rtl/ace_map.vh
// Constants for the arithmetic and control instruction executor
`ifndef ACE_MAP_VH
`define ACE_MAP_VH
// Register byte addresses
`define ACE_A_CMD      6'h00
`define ACE_A_WORK     6'h04
`define ACE_A_FLAGS    6'h08
`define ACE_A_FILE     6'h0c
`define ACE_A_PC       6'h10
`define ACE_A_SFR      6'h14
`define ACE_A_EVT      6'h18
`define ACE_A_STATE    6'h1c
// Opcodes written to the command register bits [20:16]
`define ACE_OP_NOP     5'h00
`define ACE_OP_ADDF    5'h01
`define ACE_OP_ADCF    5'h02
`define ACE_OP_ADDL    5'h03
`define ACE_OP_ADCL    5'h04
`define ACE_OP_SUBF    5'h05
`define ACE_OP_SBCF    5'h06
`define ACE_OP_SUBL    5'h07
`define ACE_OP_SBCL    5'h08
`define ACE_OP_BCDADJ  5'h09
`define ACE_OP_CMP     5'h0a
`define ACE_OP_CLRW    5'h0b
`define ACE_OP_CLRF    5'h0c
`define ACE_OP_SLEEP   5'h0d
`define ACE_OP_KICK    5'h0e
`define ACE_OP_ENI     5'h0f
`define ACE_OP_DISI    5'h10
`define ACE_OP_SWI     5'h11
`define ACE_OP_RET     5'h12
`define ACE_OP_RETINT  5'h13
`define ACE_OP_RETL    5'h14
`define ACE_OP_CALLW   5'h15
`define ACE_OP_JMPW    5'h16
`define ACE_OP_LCALL   5'h17
`define ACE_OP_LJMP    5'h18
// Flag bit positions
`define ACE_F_Z        0
`define ACE_F_HC       1
`define ACE_F_C        2
`define ACE_F_PWRDN_N  3
`define ACE_F_EXPIRY_N 4
`define ACE_F_HALT     5
`define ACE_F_GIE      6
// Cycle counts
`define ACE_CYC_ONE    2'd1
`define ACE_CYC_TWO    2'd2
`define ACE_CYC_THREE  2'd3
`define ACE_FILE_MAX   7'h7f
`define ACE_SFR_LO     4'h5
`define ACE_SFR_HI     4'hf
`define ACE_SWI_VEC    11'h008
`endif

// file: rtl/ace_exec.v
// Arithmetic and control instruction executor with AXI4-Lite register access
// Operation
// - Register add sums work and file register in one cycle, flags zero, half-carry, carry.
// - Register add-with-carry adds work, file register and carry in one cycle.
// - Literal add sums work and literal into work, flags zero, half-carry, carry.
// - Literal add-with-carry adds work, literal and carry into work.
// - Register subtract is file plus complement of work, plus carry if chained.
// - Literal subtract is literal plus complement of work into work.
// - Destination bit 0 writes work, 1 writes back to file register.
// - After addition carry is 1 on carry out of bit 7.
// - After subtraction carry is inverted borrow.
// - Decimal adjust corrects work to packed BCD, touching only carry.
// - Sleep enters halt, clears power-down flag, sets timeout flag.
// - Power-down flag is 1 at power-up and after watchdog kick.
// - Timeout flag is 1 at power-up and after kick or sleep.
// - Timeout flag clears when the watchdog counter expires.
// - Return-from-interrupt restores PC from stack, enables interrupts, two cycles.
// - Literal return pops PC and loads the literal into work.
// - Jump via work branches to target from work in two cycles.
// - Call via work pushes return address and branches to work target.
// - Literal operands are 8 bits wide.
// - File register operands address indices 0x0 to 0x7F.
// - Special register page covers indices 0x5 to 0xF.
`timescale 1ns/1ps
`include "ace_map.vh"

module ace_exec #(
   parameter STACK_DEPTH = 8,
   parameter WDT_LIMIT   = 20'd100000
) (
   // Clock and reset
   input  wire        core_clk,
   input  wire        arst_n,
   // AXI4-Lite write address and data
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [5:0]  s_axi_awaddr,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   // AXI4-Lite read
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   input  wire [5:0]  s_axi_araddr,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   // Core status
   output reg         halt_r,
   output reg         irq_enable_r
);

   // Sum of two bytes and a carry in, giving {carry, half carry, result}
   function [9:0] add8;
      input [7:0] a;
      input [7:0] b;
      input       ci;
      reg   [4:0] lo;
      reg   [8:0] full;
      begin
         lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
         full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
         add8 = {full[8], lo[4], full[7:0]};
      end
   endfunction

   // Write helper honouring byte strobes
   function [31:0] wmask;
      input [31:0] old;
      input [31:0] d;
      input [3:0]  s;
      integer i;
      begin
         wmask = old;
         for (i = 0; i < 4; i = i + 1)
            if (s[i])
               wmask[i*8 +: 8] = d[i*8 +: 8];
      end
   endfunction

   // Architectural state
   reg  [7:0]  work_r;
   reg  [7:0]  file_r [0:127];
   reg  [7:0]  sfr_r  [0:15];
   reg  [10:0] pc_r;
   reg  [10:0] stack_r [0:STACK_DEPTH-1];
   reg  [3:0]  sp_r;
   reg         z_r, c_r, half_carry_flag_r;
   reg         power_down_flag_n_r, watchdog_expiry_flag_n_r;
   reg  [10:0] tbl_hi_r;
   reg  [19:0] wdt_r;
   reg  [1:0]  busy_r;
   reg  [31:0] cmd_r;
   reg         go_r;
   reg  [7:0]  evt_r;

   // Decoded command fields
   wire [4:0]  op     = cmd_r[20:16];
   wire [7:0]  lit    = cmd_r[7:0];
   wire [6:0]  faddr  = cmd_r[6:0];
   wire        dest   = cmd_r[8];
   wire [10:0] ladr   = cmd_r[10:0];
   wire [7:0]  fval   = file_r[faddr];
   wire [10:0] pc_inc = pc_r + 11'd1;

   // Arithmetic datapath
   reg  [9:0]  alu;
   reg         is_file, uses_alu;
   always @*
   begin
      is_file  = 1'b0;
      uses_alu = 1'b1;
      case (op)
         `ACE_OP_ADDF: begin alu = add8(fval, work_r, 1'b0); is_file = 1'b1; end
         `ACE_OP_ADCF: begin alu = add8(fval, work_r, c_r);  is_file = 1'b1; end
         `ACE_OP_ADDL: alu = add8(lit, work_r, 1'b0);
         `ACE_OP_ADCL: alu = add8(lit, work_r, c_r);
         `ACE_OP_SUBF: begin alu = add8(fval, ~work_r, 1'b0); is_file = 1'b1; end
         `ACE_OP_SBCF: begin alu = add8(fval, ~work_r, c_r);  is_file = 1'b1; end
         `ACE_OP_SUBL: alu = add8(lit, ~work_r, 1'b0);
         `ACE_OP_SBCL: alu = add8(lit, ~work_r, c_r);
         `ACE_OP_CMP:  alu = add8(fval, ~work_r, 1'b0);
         default:
         begin
            alu      = 10'h000;
            uses_alu = 1'b0;
         end
      endcase
   end

   // Decimal adjust of the working register
   reg  [8:0] bcd_adj;
   always @*
   begin
      bcd_adj = {c_r, work_r};
      if (work_r[3:0] > 4'h9 || half_carry_flag_r)
         bcd_adj = bcd_adj + 9'h006;
      if (bcd_adj[7:4] > 4'h9 || c_r || bcd_adj[8])
         bcd_adj = {1'b1, bcd_adj[7:0] + 8'h60};
   end

   // Write-side capture and the software register write strobes decoded from it
   reg         aw_have_r, w_have_r;
   reg  [5:0]  aw_addr_r;
   reg  [31:0] w_data_r;
   reg  [3:0]  w_strb_r;
   wire        wr_fire    = aw_have_r && w_have_r && !s_axi_bvalid;
   // File and special page writes use the index of the last command word, as reads do
   wire [6:0]  sw_addr    = cmd_r[6:0];
   wire [31:0] sw_data    = w_data_r;
   wire        sw_file_we = wr_fire && aw_addr_r == `ACE_A_FILE && w_strb_r[0];
   wire        sw_sfr_we  = wr_fire && aw_addr_r == `ACE_A_SFR && w_strb_r[0];
   wire        sw_work_we = wr_fire && aw_addr_r == `ACE_A_WORK && w_strb_r[0];
   wire        sw_pc_we   = wr_fire && aw_addr_r == `ACE_A_PC;
   wire        wr_ok      = aw_addr_r <= `ACE_A_EVT;
   // Watchdog end of count, shared by the counter and the expiry flag
   wire        wdt_expire = (wdt_r >= WDT_LIMIT - 20'd1);

   // Instruction execution; multi-cycle ops stall in busy_r
   integer k;
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         work_r       <= 8'h00;
         pc_r         <= 11'h000;
         sp_r         <= 4'h0;
         z_r          <= 1'b0;
         half_carry_flag_r        <= 1'b0;
         c_r                      <= 1'b0;
         power_down_flag_n_r      <= 1'b1;
         watchdog_expiry_flag_n_r <= 1'b1;
         halt_r       <= 1'b0;
         irq_enable_r <= 1'b0;
         wdt_r        <= 20'h00000;
         busy_r       <= 2'd0;
         tbl_hi_r     <= 11'h000;
         evt_r        <= 8'h00;
         for (k = 0; k < 128; k = k + 1)
            file_r[k] <= 8'h00;
         for (k = 0; k < 16; k = k + 1)
            sfr_r[k] <= 8'h00;
         for (k = 0; k < STACK_DEPTH; k = k + 1)
            stack_r[k] <= 11'h000;
      end
      else
      begin
         // Watchdog runs in halt too, so it can wake a sleeping core
         if (wdt_expire)
         begin
            wdt_r  <= 20'h00000;
            watchdog_expiry_flag_n_r <= 1'b0;
            halt_r <= 1'b0;
         end
         else
            wdt_r <= wdt_r + 20'd1;
         if (busy_r != 2'd0)
            busy_r <= busy_r - 2'd1;
         // Software-side file and special register writes
         if (sw_file_we)
            file_r[sw_addr[6:0]] <= sw_data[7:0];
         if (sw_sfr_we && sw_addr[6:4] == 3'b000 && sw_addr[3:0] >= `ACE_SFR_LO)
            sfr_r[sw_addr[3:0]] <= sw_data[7:0];
         if (sw_work_we)
            work_r <= sw_data[7:0];
         if (go_r && busy_r == 2'd0 && !halt_r)
         begin
            evt_r  <= evt_r + 8'h01;
            pc_r   <= pc_inc;
            busy_r <= 2'd0;
            if (uses_alu)
            begin
               c_r  <= alu[9];
               z_r  <= (alu[7:0] == 8'h00);
               if (op != `ACE_OP_CMP)
               begin
                  half_carry_flag_r <= alu[8];
                  if (is_file && dest)
                     file_r[faddr] <= alu[7:0];
                  else
                     work_r <= alu[7:0];
               end
            end
            case (op)
               `ACE_OP_BCDADJ:
               begin
                  work_r <= bcd_adj[7:0];
                  c_r    <= bcd_adj[8];
               end
               `ACE_OP_CLRW:
               begin
                  work_r <= 8'h00;
                  z_r    <= 1'b1;
               end
               `ACE_OP_CLRF:
               begin
                  file_r[faddr] <= 8'h00;
                  z_r           <= 1'b1;
               end
               `ACE_OP_SLEEP:
               begin
                  halt_r <= 1'b1;
                  power_down_flag_n_r      <= 1'b0;
                  watchdog_expiry_flag_n_r <= 1'b1;
                  wdt_r  <= 20'h00000;
               end
               `ACE_OP_KICK:
               begin
                  power_down_flag_n_r      <= 1'b1;
                  watchdog_expiry_flag_n_r <= 1'b1;
                  wdt_r  <= 20'h00000;
               end
               `ACE_OP_ENI:  irq_enable_r <= 1'b1;
               `ACE_OP_DISI: irq_enable_r <= 1'b0;
               `ACE_OP_SWI:
               begin
                  stack_r[sp_r[2:0]] <= pc_inc;
                  sp_r   <= sp_r + 4'h1;
                  pc_r   <= `ACE_SWI_VEC;
                  irq_enable_r <= 1'b0;
                  busy_r <= `ACE_CYC_THREE - 2'd1;
               end
               `ACE_OP_RET, `ACE_OP_RETINT, `ACE_OP_RETL:
               begin
                  pc_r   <= stack_r[sp_r[2:0] - 3'd1];
                  sp_r   <= sp_r - 4'h1;
                  busy_r <= `ACE_CYC_TWO - 2'd1;
                  if (op == `ACE_OP_RETINT)
                     irq_enable_r <= 1'b1;
                  if (op == `ACE_OP_RETL)
                     work_r <= lit;
               end
               `ACE_OP_CALLW, `ACE_OP_LCALL:
               begin
                  stack_r[sp_r[2:0]] <= pc_inc;
                  sp_r   <= sp_r + 4'h1;
                  pc_r   <= (op == `ACE_OP_LCALL) ? ladr : {tbl_hi_r[10:8], work_r};
                  busy_r <= `ACE_CYC_TWO - 2'd1;
               end
               `ACE_OP_JMPW, `ACE_OP_LJMP:
               begin
                  pc_r   <= (op == `ACE_OP_LJMP) ? ladr : {tbl_hi_r[10:8], work_r};
                  busy_r <= `ACE_CYC_TWO - 2'd1;
               end
               default: ;
            endcase
         end
         // On the timeout flag, a timeout beats a kick or sleep landing in the same cycle
         if (wdt_expire)
            watchdog_expiry_flag_n_r <= 1'b0;
         if (sw_pc_we)
            tbl_hi_r <= sw_data[26:16];
      end
   end

   // AXI4-Lite slave: address and data are latched independently

   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         aw_addr_r     <= 6'h00;
         w_data_r      <= 32'h00000000;
         w_strb_r      <= 4'h0;
         cmd_r         <= 32'h00000000;
         go_r          <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         // Command launch is one pulse; it waits while a multi-cycle op drains
         if (go_r && busy_r == 2'd0 && !halt_r)
            go_r <= 1'b0;
         if (wr_fire)
         begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            if (aw_addr_r == `ACE_A_CMD)
            begin
               cmd_r <= wmask(cmd_r, w_data_r, w_strb_r);
               go_r  <= 1'b1;
            end
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: registered data, one request at a time
   reg [31:0] rd_mux;
   always @*
   begin
      case (s_axi_araddr)
         `ACE_A_CMD:   rd_mux = cmd_r;
         `ACE_A_WORK:  rd_mux = {24'h000000, work_r};
         `ACE_A_FLAGS: rd_mux = {25'h0000000, irq_enable_r, halt_r, watchdog_expiry_flag_n_r,
                                 power_down_flag_n_r, c_r, half_carry_flag_r, z_r};
         `ACE_A_FILE:  rd_mux = {24'h000000, file_r[cmd_r[6:0]]};
         `ACE_A_PC:    rd_mux = {5'h00, tbl_hi_r, 5'h00, pc_r};
         `ACE_A_SFR:   rd_mux = {24'h000000, sfr_r[cmd_r[3:0]]};
         `ACE_A_EVT:   rd_mux = {24'h000000, evt_r};
         `ACE_A_STATE: rd_mux = {26'h0000000, busy_r, go_r, sp_r[2:0]};
         default:      rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'b00;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= (s_axi_araddr > `ACE_A_STATE || s_axi_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule // ace_exec

// file: verif/ace_exec_checker.sv
// Concurrent checks on the ports of the arithmetic and control executor
`timescale 1ns/1ps
`include "ace_map.vh"
module ace_exec_checker (
   // Clock and reset
   input wire        core_clk,
   input wire        arst_n,
   // Register bus
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [5:0]  s_axi_awaddr,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [5:0]  s_axi_araddr,
   input wire        s_axi_rvalid,
   input wire [1:0]  s_axi_rresp,
   // Core status
   input wire        halt_r,
   input wire        irq_enable_r
);
   reg  [5:0] aw_q;
   reg  [5:0] ar_q;
   reg  [4:0] op_q;
   reg  [3:0] since_cmd;
   reg  [3:0] since_sleep;
   wire       cmd_done = s_axi_bvalid && s_axi_bready && (aw_q == `ACE_A_CMD);

   // Track addresses and opcode in flight; ages saturate so old commands never look recent
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aw_q        <= 6'h00;
         ar_q        <= 6'h00;
         op_q        <= 5'h00;
         since_cmd   <= 4'hf;
         since_sleep <= 4'hf;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
            aw_q <= s_axi_awaddr;
         if (s_axi_arvalid && s_axi_arready)
            ar_q <= s_axi_araddr;
         if (s_axi_wvalid && s_axi_wready)
            op_q <= s_axi_wdata[20:16];
         since_cmd   <= cmd_done ? 4'h0 : ((since_cmd == 4'hf) ? 4'hf : since_cmd + 4'h1);
         since_sleep <= (cmd_done && op_q == `ACE_OP_SLEEP) ? 4'h0 :
                        ((since_sleep == 4'hf) ? 4'hf : since_sleep + 4'h1);
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   AST_SLEEP_HALT: assert property (cmd_done && op_q == `ACE_OP_SLEEP && !halt_r |-> ##[1:3] halt_r)
      else $error("sleep did not halt the core");
   AST_HALT_CAUSE: assert property ($rose(halt_r) |-> since_sleep <= 4'd4)
      else $error("halt rose without a sleep command");
   AST_HALT_FREEZE: assert property (halt_r && $past(halt_r) |-> $stable(irq_enable_r))
      else $error("interrupt enable moved while halted");
   AST_RETURN_IRQ: assert property (cmd_done && op_q == `ACE_OP_RETINT |-> ##[1:4] irq_enable_r)
      else $error("return from interrupt left interrupts off");
   AST_IRQ_CAUSE: assert property ($changed(irq_enable_r) |-> since_cmd <= 4'd5)
      else $error("interrupt enable changed with no command");
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read answer late");
   AST_RD_ERR: assert property (s_axi_rvalid && (ar_q > 6'h1c || ar_q[1:0] != 2'b00) |-> s_axi_rresp == 2'b10)
      else $error("unmapped read not refused");
   AST_WR_ERR: assert property (s_axi_bvalid && aw_q > 6'h18 |-> s_axi_bresp == 2'b10)
      else $error("unmapped write not refused");

   // Main scenarios reached
   cover property (cmd_done && op_q == `ACE_OP_SLEEP);
   cover property ($fell(halt_r));
   cover property (cmd_done && op_q == `ACE_OP_RETINT);
endmodule // ace_exec_checker

bind ace_exec ace_exec_checker u_chk (.core_clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
   .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rresp, .halt_r, .irq_enable_r);

// file: verif/ace_exec_tb.sv
// Self-checking bench for the arithmetic and control executor
`timescale 1ns/1ps
`include "ace_map.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: %h not %h", $time, g, e); end end

module ace_exec_tb;
   // Bus drive and observe
   logic        core_clk = 1'b0;
   logic        arst_n   = 1'b0;
   logic        awv      = 1'b0;
   logic        wv       = 1'b0;
   logic        bry      = 1'b0;
   logic        arv      = 1'b0;
   logic        rry      = 1'b0;
   logic [5:0]  awa      = 6'h00;
   logic [5:0]  ara      = 6'h00;
   logic [31:0] wd       = 32'h0;
   logic [3:0]  ws       = 4'h0;
   wire         awr, wry, bv, arr, rv, halt_r, irq_enable_r;
   wire  [1:0]  br, rr;
   wire  [31:0] rdat;
   // Reference state of work, flags and file page
   logic [7:0]  wm = 8'h00;
   logic [7:0]  fm [0:127] = '{default: 8'h00};
   logic        cm = 1'b0, dcm = 1'b0, zm = 1'b0;
   int          n_fail = 0, total_checks = 0;

   // Watchdog shortened so sleep wake-up fits in a short run
   ace_exec #(.STACK_DEPTH(8), .WDT_LIMIT(20'd200)) dut (
      .core_clk(core_clk), .arst_n(arst_n), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wry), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdat), .s_axi_rresp(rr), .halt_r(halt_r),
      .irq_enable_r(irq_enable_r));

   always #5 core_clk = ~core_clk;

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // One transfer; each valid is held until its own ready, ready lowered a cycle before reuse
   task automatic axi(input bit w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      bit got;
      got = 1'b0;
      if (w)
      begin
         awa <= a;
         wd  <= d;
         ws  <= (a == `ACE_A_CMD) ? 4'hf : 4'h1;
         awv <= 1'b1;
         wv  <= 1'b1;
         bry <= 1'b1;
      end
      else
      begin
         ara <= a;
         arv <= 1'b1;
         rry <= 1'b1;
      end
      while (!got)
      begin
         @(posedge core_clk);
         if (awr === 1'b1)
            awv <= 1'b0;
         if (wry === 1'b1)
            wv <= 1'b0;
         if (arr === 1'b1)
            arv <= 1'b0;
         got = w ? (bv === 1'b1) : (rv === 1'b1);
         r   = w ? br : rr;
         q   = rdat;
      end
      bry <= 1'b0;
      rry <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic wreg(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0]  r;
      axi(1'b1, a, d, q, r);
      `CHK(r, 2'b00)
   endtask

   task automatic rreg(input logic [5:0] a, output logic [31:0] q);
      logic [1:0] r;
      axi(1'b0, a, 32'h0, q, r);
      `CHK(r, 2'b00)
   endtask

   task automatic ex(input logic [4:0] op, input logic dst, input logic [7:0] lit);
      wreg(`ACE_A_CMD, {11'h000, op, 7'h00, dst, lit});
   endtask

   // Preset work, run one arithmetic command, then compare work, flags and file
   task automatic arith(input logic [7:0] w0, input logic [4:0] op, input logic dst, input logic [7:0] lit);
      logic [7:0]  b, x;
      logic [8:0]  s;
      logic [31:0] q;
      logic        ci, lop, cmp;
      wreg(`ACE_A_WORK, {24'h0, w0});
      wm  = w0;
      cmp = (op == `ACE_OP_CMP);
      lop = (op inside {`ACE_OP_ADDL, `ACE_OP_ADCL, `ACE_OP_SUBL, `ACE_OP_SBCL});
      ci  = (op inside {`ACE_OP_ADCF, `ACE_OP_ADCL, `ACE_OP_SBCF, `ACE_OP_SBCL}) ? cm : 1'b0;
      x   = (op inside {`ACE_OP_SUBF, `ACE_OP_SBCF, `ACE_OP_SUBL, `ACE_OP_SBCL, `ACE_OP_CMP}) ? ~wm : wm;
      b   = lop ? lit : fm[lit[6:0]];
      s   = b + x + ci;
      ex(op, dst, lit);
      if (op == `ACE_OP_BCDADJ)
      begin
         s = wm + (((wm[3:0] > 4'h9) || dcm) ? 9'h006 : 9'h000);
         if (s > 9'h09f || cm)
         begin
            s  = s + 9'h060;
            cm = 1'b1;
         end
         wm = s[7:0];
      end
      else if (op == `ACE_OP_CLRW || op == `ACE_OP_CLRF)
      begin
         zm = 1'b1;
         if (op == `ACE_OP_CLRW)
            wm = 8'h00;
         else
            fm[lit[6:0]] = 8'h00;
      end
      else
      begin
         zm = (s[7:0] == 8'h00);
         cm = s[8];
         if (!cmp)
            dcm = (b[3:0] + x[3:0] + ci) > 5'd15;
         if (!cmp && dst && !lop)
            fm[lit[6:0]] = s[7:0];
         else if (!cmp)
            wm = s[7:0];
      end
      rreg(`ACE_A_WORK, q);
      `CHK(q[7:0], wm)
      rreg(`ACE_A_FLAGS, q);
      `CHK(q[2:0], {cm, dcm, zm})
      rreg(`ACE_A_FILE, q);
      `CHK(q[7:0], fm[lit[6:0]])
   endtask

   // Main sequence
   initial
   begin
      logic [31:0] q;
      logic [1:0]  r;
      int          n;
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      rreg(`ACE_A_FLAGS, q);
      `CHK(q[6:0], 7'h18)
      arith(8'h12, `ACE_OP_ADDL, 1'b0, 8'h34);
      arith(8'hff, `ACE_OP_ADDL, 1'b0, 8'h01);
      arith(8'h12, `ACE_OP_ADCL, 1'b0, 8'h34);
      arith(8'h0f, `ACE_OP_ADDF, 1'b1, 8'h7f);
      arith(8'h01, `ACE_OP_ADDF, 1'b0, 8'h7f);
      arith(8'hf0, `ACE_OP_ADDF, 1'b1, 8'h7f);
      arith(8'h01, `ACE_OP_ADDF, 1'b1, 8'h7f);
      arith(8'h22, `ACE_OP_ADCF, 1'b0, 8'h7f);
      arith(8'h30, `ACE_OP_ADDF, 1'b1, 8'h10);
      arith(8'h10, `ACE_OP_SUBF, 1'b0, 8'h10);
      arith(8'h40, `ACE_OP_SBCF, 1'b1, 8'h10);
      arith(8'h05, `ACE_OP_SUBL, 1'b0, 8'h03);
      arith(8'h05, `ACE_OP_SBCL, 1'b0, 8'h09);
      arith(8'h30, `ACE_OP_CMP, 1'b1, 8'h10);
      arith(8'h9a, `ACE_OP_BCDADJ, 1'b0, 8'h00);
      arith(8'h55, `ACE_OP_CLRW, 1'b0, 8'h00);
      arith(8'h07, `ACE_OP_CLRF, 1'b0, 8'h10);
      // Sleep, wake by watchdog expiry, then kick
      ex(`ACE_OP_SLEEP, 1'b0, 8'h00);
      rreg(`ACE_A_FLAGS, q);
      `CHK({halt_r, q[5:3]}, 4'b1110)
      n = 0;
      while (halt_r !== 1'b0 && n < 500)
      begin
         @(posedge core_clk);
         n++;
      end
      rreg(`ACE_A_FLAGS, q);
      `CHK({halt_r, q[4]}, 2'b00)
      ex(`ACE_OP_KICK, 1'b0, 8'h00);
      rreg(`ACE_A_FLAGS, q);
      `CHK(q[4:3], 2'b11)
      // Control flow through work; table high part is zero after reset
      wreg(`ACE_A_WORK, 32'h40);
      ex(`ACE_OP_JMPW, 1'b0, 8'h00);
      rreg(`ACE_A_PC, q);
      `CHK(q[10:0], 11'h040)
      wreg(`ACE_A_WORK, 32'h80);
      ex(`ACE_OP_CALLW, 1'b0, 8'h00);
      rreg(`ACE_A_PC, q);
      `CHK(q[10:0], 11'h080)
      ex(`ACE_OP_RETL, 1'b0, 8'h5a);
      rreg(`ACE_A_PC, q);
      `CHK(q[10:0], 11'h041)
      rreg(`ACE_A_WORK, q);
      `CHK(q[7:0], 8'h5a)
      wreg(`ACE_A_WORK, 32'h20);
      ex(`ACE_OP_CALLW, 1'b0, 8'h00);
      ex(`ACE_OP_RETINT, 1'b0, 8'h00);
      rreg(`ACE_A_PC, q);
      `CHK({irq_enable_r, q[10:0]}, 12'h842)
      // Interrupt enable, software interrupt and long branches
      ex(`ACE_OP_DISI, 1'b0, 8'h00);
      `CHK(irq_enable_r, 1'b0)
      ex(`ACE_OP_ENI, 1'b0, 8'h00);
      `CHK(irq_enable_r, 1'b1)
      ex(`ACE_OP_SWI, 1'b0, 8'h00);
      rreg(`ACE_A_PC, q);
      `CHK({irq_enable_r, q[10:0]}, 12'h008)
      ex(`ACE_OP_RET, 1'b0, 8'h00);
      rreg(`ACE_A_PC, q);
      `CHK(q[10:0], 11'h045)
      ex(`ACE_OP_LJMP, 1'b1, 8'ha5);
      ex(`ACE_OP_LCALL, 1'b0, 8'hc3);
      rreg(`ACE_A_PC, q);
      `CHK(q[10:0], 11'h0c3)
      ex(`ACE_OP_RET, 1'b0, 8'h00);
      rreg(`ACE_A_PC, q);
      `CHK(q[10:0], 11'h1a6)
      // Special page takes indices 5 to 15 only; the index is the last command's
      ex(`ACE_OP_NOP, 1'b0, 8'h05);
      wreg(`ACE_A_SFR, 32'ha5);
      rreg(`ACE_A_SFR, q);
      `CHK(q[7:0], 8'ha5)
      ex(`ACE_OP_NOP, 1'b0, 8'h03);
      wreg(`ACE_A_SFR, 32'h77);
      rreg(`ACE_A_SFR, q);
      `CHK(q[7:0], 8'h00)
      // Unmapped places are refused
      axi(1'b1, 6'h1c, 32'h0, q, r);
      `CHK(r, 2'b10)
      axi(1'b0, 6'h20, 32'h0, q, r);
      `CHK(r, 2'b10)
      test_done();
   end

   // Hang guard, far beyond the several hundred cycles the sequence needs
   initial
   begin
      #100000;
      n_fail++;
      test_done();
   end
endmodule // ace_exec_tb
